// ===== inc/sector_overlay_pkg.sv
/*
  Shared types and constants of the sector lock and ECC overlay command
  decoder: command codes, unlock addresses, address field positions,
  register offsets and the packed carriers for the command, answer, engine, ECC event and AXI ports.
  Assumes a single 125 MHz clock and word (16-bit) command addressing.
*/
`default_nettype none
package sector_overlay_pkg;
  localparam int ADDR_W      = 25;
  localparam int DATA_W      = 16;
  localparam int MAIN_SHIFT  = 17;
  localparam int PARAM_SHIFT = 11;
  localparam int NPARAM      = 8;
  localparam int NMAIN       = 1 << (ADDR_W - MAIN_SHIFT);
  localparam int NSECT       = NMAIN + NPARAM;
  localparam int SECT_W      = $clog2(NSECT);
  localparam int UNLK_W      = 11;
  localparam int REG_SEL_W   = 4;
  localparam int AXI_AW      = 8;
  localparam int AXI_DW      = 32;

  localparam logic [UNLK_W-1:0] UNLK_ADDR1 = 11'h555;
  localparam logic [UNLK_W-1:0] UNLK_ADDR2 = 11'h2AA;

  localparam logic [7:0] CODE_UNLK1     = 8'hAA;
  localparam logic [7:0] CODE_UNLK2     = 8'h55;
  localparam logic [7:0] CODE_LOCK_ENT  = 8'hE0;
  localparam logic [7:0] CODE_ECC_ENT   = 8'h75;
  localparam logic [7:0] CODE_ID_ENT    = 8'h90;
  localparam logic [7:0] CODE_EXIT1     = 8'h90;
  localparam logic [7:0] CODE_EXIT2     = 8'h00;
  localparam logic [7:0] CODE_RESET     = 8'hF0;
  localparam logic [7:0] CODE_PROGRAM   = 8'hA0;
  localparam logic [7:0] CODE_STATUS    = 8'h60;
  localparam logic [7:0] CODE_ECC_CLR   = 8'h50;
  localparam logic [7:0] CODE_ERASE_SUS = 8'hB0;
  localparam logic [7:0] CODE_ERASE_RES = 8'h30;
  localparam logic [7:0] CODE_PROG_SUS  = 8'h51;
  localparam logic [7:0] CODE_PROG_RES  = 8'h50;

  localparam logic [REG_SEL_W-1:0] SEL_ERR_LO  = 4'h1;
  localparam logic [REG_SEL_W-1:0] SEL_ERR_HI  = 4'h2;
  localparam logic [REG_SEL_W-1:0] SEL_ERR_CNT = 4'h3;

  localparam logic [DATA_W-1:0] ALL_ONES      = 16'hFFFF;
  localparam logic [DATA_W-1:0] PROT_CFG_RST  = 16'hFFFF;
  localparam int                PERSIST_BIT   = 1;
  localparam int                PASSWORD_BIT  = 2;
  localparam logic              LOCK_RST      = 1'b1;
  localparam logic              PARAM_EN_RST  = 1'b1;

  localparam logic [AXI_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_PROT_CFG = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_ECC_CNT  = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_ERR_LO   = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_ERR_HI   = 8'h14;
  localparam int                ST_ABORT_BIT = 4;
  localparam logic [1:0]        RESP_OKAY    = 2'h0;
  localparam logic [1:0]        RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic              valid;
    logic              wr;
    logic              first;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } resp_t;

  typedef struct packed {
    logic              prog;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              erase_sus;
    logic              erase_res;
    logic              prog_sus;
    logic              prog_res;
  } op_req_t;

  typedef struct packed {
    logic              erase_busy;
    logic              erase_suspended;
    logic              prog_busy;
    logic              prog_suspended;
    logic              wbuf_abort;
    logic [SECT_W-1:0] erase_sector;
  } op_stat_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } ecc_evt_t;

  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [AXI_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
  } axi_rsp_t;
endpackage
`default_nettype wire

// ===== verilog/sector_overlay_cmd.sv
/*
  Command decoder for the volatile sector lock overlay and the ECC status
  overlay, with unlock, entry, exit, suspend and abort recovery handling,
  plus an AXI4-Lite slave for control, status and protection config.
  Assumes command cycles arrive already decoded one per clock from the
  host side, and array, ECC and ID words are returned combinationally.
*/
// Our own choices: the address map and the AXI4-Lite register port.
`default_nettype none
module sector_overlay_cmd (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire sector_overlay_pkg::axi_req_t    axi_req,
  output var  sector_overlay_pkg::axi_rsp_t    axi_rsp,
  input  wire sector_overlay_pkg::cmd_t        cmd,
  output var  sector_overlay_pkg::resp_t       resp,
  input  wire logic [15:0]                     arr_rdata,
  input  wire logic [15:0]                     ecc_word,
  input  wire logic [15:0]                     id_rdata,
  input  wire logic [sector_overlay_pkg::NSECT-1:0] persist_unlock,
  input  wire sector_overlay_pkg::ecc_evt_t    ecc_evt,
  input  wire sector_overlay_pkg::op_stat_t    op_stat,
  output var  sector_overlay_pkg::op_req_t     op_req
);
  typedef enum logic [3:0] {
    ST_ARRAY, ST_UNLK1, ST_UNLK2, ST_PROG, ST_LOCK, ST_LOCK_A0,
    ST_LOCK_60, ST_LOCK_90, ST_ECC, ST_ECC_60, ST_ID, ST_ID_90, ST_ABORT
  } state_t;

  state_t                                      state_ff;
  logic                                        from_abort_ff;
  logic [sector_overlay_pkg::NSECT-1:0]        unlock_ff;
  logic [15:0]                                 err_lo_ff;
  logic [15:0]                                 err_hi_ff;
  logic [15:0]                                 err_cnt_ff;
  logic [15:0]                                 prot_cfg_ff;
  logic                                        prot_abort_ff;
  logic                                        param_en_ff;
  logic                                        aw_got_ff;
  logic                                        w_got_ff;
  logic [sector_overlay_pkg::AXI_AW-1:0]       aw_addr_ff;
  logic [31:0]                                 w_data_ff;
  logic [3:0]                                  w_strb_ff;

  // Sector index; low parameter sectors only when enabled
  function automatic logic [sector_overlay_pkg::SECT_W-1:0] sect_of(
      input logic [sector_overlay_pkg::ADDR_W-1:0] a,
      input logic                                  pen);
    logic [5:0] psel;
    psel = a[sector_overlay_pkg::MAIN_SHIFT-1:sector_overlay_pkg::PARAM_SHIFT];
    if (pen && a[sector_overlay_pkg::ADDR_W-1:sector_overlay_pkg::MAIN_SHIFT]
        == '0 && 32'(psel) < sector_overlay_pkg::NPARAM) begin
      sect_of = sector_overlay_pkg::SECT_W'(sector_overlay_pkg::NMAIN)
              + sector_overlay_pkg::SECT_W'(psel);
    end else begin
      sect_of = sector_overlay_pkg::SECT_W'(
        a[sector_overlay_pkg::ADDR_W-1:sector_overlay_pkg::MAIN_SHIFT]);
    end
  endfunction

  // Only the low byte and low address field take part in matching
  function automatic logic is_cmd(input sector_overlay_pkg::cmd_t c,
                                  input logic [7:0] code);
    is_cmd = c.data[7:0] == code;
  endfunction

  function automatic logic at_unlk(input sector_overlay_pkg::cmd_t c,
                                   input logic [10:0] ua);
    at_unlk = c.addr[sector_overlay_pkg::UNLK_W-1:0] == ua;
  endfunction

  logic                                 wr_cyc;
  logic                                 rd_cyc;
  logic [sector_overlay_pkg::SECT_W-1:0] cmd_sect;
  logic                                 in_erase_sect;
  state_t                               base_state;
  assign wr_cyc        = cmd.valid && cmd.wr;
  assign rd_cyc        = cmd.valid && !cmd.wr;
  assign cmd_sect      = sect_of(cmd.addr, param_en_ff);
  assign in_erase_sect = op_stat.erase_suspended
                         && cmd_sect == op_stat.erase_sector;
  assign base_state    = from_abort_ff ? ST_ABORT : ST_ARRAY;

  // Command sequence state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ST_ARRAY;
      from_abort_ff <= 1'b0;
    end else if (op_stat.wbuf_abort && state_ff == ST_PROG) begin
      state_ff      <= ST_ABORT;
      from_abort_ff <= 1'b1;
    end else if (wr_cyc) begin
      case (state_ff)
        ST_ARRAY: begin
          if (is_cmd(cmd, sector_overlay_pkg::CODE_UNLK1)
              && at_unlk(cmd, sector_overlay_pkg::UNLK_ADDR1)) begin
            state_ff <= ST_UNLK1;
          end
        end
        ST_ABORT: begin
          // A lone reset is ignored here; only the full sequence leaves
          if (is_cmd(cmd, sector_overlay_pkg::CODE_UNLK1)
              && at_unlk(cmd, sector_overlay_pkg::UNLK_ADDR1)) begin
            state_ff <= ST_UNLK1;
          end
        end
        ST_UNLK1: begin
          if (is_cmd(cmd, sector_overlay_pkg::CODE_UNLK2)
              && at_unlk(cmd, sector_overlay_pkg::UNLK_ADDR2)) begin
            state_ff <= ST_UNLK2;
          end else begin
            state_ff <= base_state;
          end
        end
        ST_UNLK2: begin
          state_ff <= base_state;
          if (!at_unlk(cmd, sector_overlay_pkg::UNLK_ADDR1)) begin
            state_ff <= base_state;
          end else if (from_abort_ff) begin
            if (is_cmd(cmd, sector_overlay_pkg::CODE_RESET)) begin
              state_ff      <= ST_ARRAY;
              from_abort_ff <= 1'b0;
            end
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_LOCK_ENT)
                       && !op_stat.erase_suspended) begin
            state_ff <= ST_LOCK;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_ECC_ENT)
                       && !op_stat.erase_suspended) begin
            state_ff <= ST_ECC;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_ID_ENT)) begin
            state_ff <= ST_ID;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_PROGRAM)) begin
            state_ff <= ST_PROG;
          end
        end
        ST_PROG:    state_ff <= ST_ARRAY;
        ST_LOCK: begin
          if (is_cmd(cmd, sector_overlay_pkg::CODE_PROGRAM)) begin
            state_ff <= ST_LOCK_A0;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_STATUS)) begin
            state_ff <= ST_LOCK_60;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_EXIT1)) begin
            state_ff <= ST_LOCK_90;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_RESET)) begin
            state_ff <= ST_ARRAY;
          end
        end
        ST_LOCK_A0: state_ff <= ST_LOCK;
        ST_LOCK_60: state_ff <= ST_LOCK;
        ST_LOCK_90: begin
          state_ff <= is_cmd(cmd, sector_overlay_pkg::CODE_EXIT2)
                      ? ST_ARRAY : ST_LOCK;
        end
        ST_ECC: begin
          if (is_cmd(cmd, sector_overlay_pkg::CODE_STATUS)) begin
            state_ff <= ST_ECC_60;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_RESET)) begin
            state_ff <= ST_ARRAY;
          end
        end
        ST_ECC_60:  state_ff <= ST_ECC;
        ST_ID: begin
          if (is_cmd(cmd, sector_overlay_pkg::CODE_EXIT1)) begin
            state_ff <= ST_ID_90;
          end else if (is_cmd(cmd, sector_overlay_pkg::CODE_RESET)) begin
            state_ff <= ST_ARRAY;
          end
        end
        ST_ID_90: begin
          state_ff <= is_cmd(cmd, sector_overlay_pkg::CODE_EXIT2)
                      ? ST_ARRAY : ST_ID;
        end
        default:    state_ff <= ST_ARRAY;
      endcase
    end else if (rd_cyc && (state_ff == ST_LOCK_60
                            || state_ff == ST_ECC_60)) begin
      state_ff <= (state_ff == ST_LOCK_60) ? ST_LOCK : ST_ECC;
    end
  end

  // Volatile lock bits; any word in the sector selects it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_ff <= {sector_overlay_pkg::NSECT{sector_overlay_pkg::LOCK_RST}};
    end else if (wr_cyc && state_ff == ST_LOCK_A0) begin
      unlock_ff[cmd_sect] <= cmd.data[0];
    end
  end

  // Error capture; a new event in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_lo_ff  <= '0;
      err_hi_ff  <= '0;
      err_cnt_ff <= '0;
    end else if (ecc_evt.valid) begin
      err_lo_ff <= ecc_evt.addr[15:0];
      err_hi_ff <= 16'(ecc_evt.addr[sector_overlay_pkg::ADDR_W-1:16]);
      if (wr_cyc && state_ff == ST_ECC
          && is_cmd(cmd, sector_overlay_pkg::CODE_ECC_CLR)) begin
        err_cnt_ff <= 16'h0001;
      end else if (err_cnt_ff != sector_overlay_pkg::ALL_ONES) begin
        err_cnt_ff <= err_cnt_ff + 16'h0001;
      end
    end else if (wr_cyc && state_ff == ST_ECC
                 && is_cmd(cmd, sector_overlay_pkg::CODE_ECC_CLR)) begin
      err_lo_ff  <= '0;
      err_hi_ff  <= '0;
      err_cnt_ff <= '0;
    end
  end

  // Read answers, one cycle after the read cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp <= '0;
    end else begin
      resp.valid <= rd_cyc;
      if (rd_cyc) begin
        case (state_ff)
          ST_LOCK:
            resp.data <= {15'h7FFF, unlock_ff[cmd_sect]};
          ST_LOCK_60:
            resp.data <= {13'h1FFF, persist_unlock[cmd_sect],
                          unlock_ff[cmd_sect],
                          persist_unlock[cmd_sect]
                          & unlock_ff[cmd_sect]};
          ST_ECC:     resp.data <= ecc_word;
          ST_ECC_60: begin
            case (cmd.addr[sector_overlay_pkg::REG_SEL_W-1:0])
              sector_overlay_pkg::SEL_ERR_LO:  resp.data <= err_lo_ff;
              sector_overlay_pkg::SEL_ERR_HI:  resp.data <= err_hi_ff;
              sector_overlay_pkg::SEL_ERR_CNT: resp.data <= err_cnt_ff;
              default: resp.data <= sector_overlay_pkg::ALL_ONES;
            endcase
          end
          ST_ID, ST_ID_90: resp.data <= id_rdata;
          default: begin
            // Reads in the sector under a suspended erase are refused
            resp.data <= in_erase_sect ? sector_overlay_pkg::ALL_ONES
                                       : arr_rdata;
          end
        endcase
        if (!cmd.first && state_ff inside {ST_LOCK, ST_LOCK_60,
                                           ST_ECC, ST_ECC_60}) begin
          resp.data <= sector_overlay_pkg::ALL_ONES;
        end
      end
    end
  end

  // Requests to the embedded program and erase engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_req <= '0;
    end else begin
      op_req.prog      <= wr_cyc && state_ff == ST_PROG
                          && !in_erase_sect;
      op_req.addr      <= cmd.addr;
      op_req.data      <= cmd.data;
      op_req.erase_sus <= wr_cyc && state_ff == ST_ARRAY
                          && is_cmd(cmd, sector_overlay_pkg::CODE_ERASE_SUS)
                          && op_stat.erase_busy;
      op_req.erase_res <= wr_cyc && state_ff == ST_ARRAY
                          && is_cmd(cmd, sector_overlay_pkg::CODE_ERASE_RES)
                          && op_stat.erase_suspended;
      op_req.prog_sus  <= wr_cyc && state_ff == ST_ARRAY
                          && is_cmd(cmd, sector_overlay_pkg::CODE_PROG_SUS)
                          && op_stat.prog_busy;
      op_req.prog_res  <= wr_cyc && state_ff == ST_ARRAY
                          && is_cmd(cmd, sector_overlay_pkg::CODE_PROG_RES)
                          && op_stat.prog_suspended;
    end
  end

  // AXI4-Lite channel handshakes
  logic wr_fire;
  logic rd_fire;
  logic aw_hit;
  logic w_hit;
  assign aw_hit  = axi_req.awvalid && axi_rsp.awready;
  assign w_hit   = axi_req.wvalid && axi_rsp.wready;
  assign wr_fire = aw_got_ff && w_got_ff && !axi_rsp.bvalid;
  assign rd_fire = axi_req.arvalid && axi_rsp.arready;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {sector_overlay_pkg::OFS_CTRL,
                       sector_overlay_pkg::OFS_STATUS,
                       sector_overlay_pkg::OFS_PROT_CFG,
                       sector_overlay_pkg::OFS_ECC_CNT,
                       sector_overlay_pkg::OFS_ERR_LO,
                       sector_overlay_pkg::OFS_ERR_HI};
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp    <= '0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
    end else begin
      axi_rsp.awready <= !aw_got_ff && !aw_hit && !axi_rsp.bvalid
                         && axi_req.awvalid;
      axi_rsp.wready  <= !w_got_ff && !w_hit && !axi_rsp.bvalid
                         && axi_req.wvalid;
      if (aw_hit) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= axi_req.awaddr;
      end
      if (w_hit) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= axi_req.wdata;
        w_strb_ff <= axi_req.wstrb;
      end
      if (wr_fire) begin
        aw_got_ff       <= 1'b0;
        w_got_ff        <= 1'b0;
        axi_rsp.bvalid  <= 1'b1;
        axi_rsp.bresp   <= mapped(aw_addr_ff) ? sector_overlay_pkg::RESP_OKAY
                                              : sector_overlay_pkg::RESP_SLVERR;
      end else if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
      end
      axi_rsp.arready <= axi_req.arvalid && !rd_fire && !axi_rsp.rvalid;
      if (rd_fire) begin
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rresp  <= mapped(axi_req.araddr)
                          ? sector_overlay_pkg::RESP_OKAY
                          : sector_overlay_pkg::RESP_SLVERR;
        case (axi_req.araddr)
          sector_overlay_pkg::OFS_CTRL:
            axi_rsp.rdata <= {31'h0000_0000, param_en_ff};
          sector_overlay_pkg::OFS_STATUS:
            axi_rsp.rdata <= {25'h000_0000, op_stat.prog_suspended,
                              op_stat.erase_suspended, prot_abort_ff,
                              state_ff == ST_ABORT,
                              state_ff inside {ST_ID, ST_ID_90},
                              state_ff inside {ST_ECC, ST_ECC_60},
                              state_ff inside {ST_LOCK, ST_LOCK_A0,
                                               ST_LOCK_60, ST_LOCK_90}};
          sector_overlay_pkg::OFS_PROT_CFG:
            axi_rsp.rdata <= {16'h0000, prot_cfg_ff};
          sector_overlay_pkg::OFS_ECC_CNT:
            axi_rsp.rdata <= {16'h0000, err_cnt_ff};
          sector_overlay_pkg::OFS_ERR_LO:
            axi_rsp.rdata <= {16'h0000, err_lo_ff};
          sector_overlay_pkg::OFS_ERR_HI:
            axi_rsp.rdata <= {16'h0000, err_hi_ff};
          default: axi_rsp.rdata <= '0;
        endcase
      end else if (axi_rsp.rvalid && axi_req.rready) begin
        axi_rsp.rvalid <= 1'b0;
      end
    end
  end

  // Register writes; protection config bits only ever move from 1 to 0
  logic [15:0] otp_wd;
  assign otp_wd = w_data_ff[15:0]
                  | ~{{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_en_ff   <= sector_overlay_pkg::PARAM_EN_RST;
      prot_cfg_ff   <= sector_overlay_pkg::PROT_CFG_RST;
      prot_abort_ff <= 1'b0;
    end else if (wr_fire) begin
      case (aw_addr_ff)
        sector_overlay_pkg::OFS_CTRL: begin
          if (w_strb_ff[0]) begin
            param_en_ff <= w_data_ff[0];
          end
        end
        sector_overlay_pkg::OFS_STATUS: begin
          if (w_strb_ff[0] && w_data_ff[sector_overlay_pkg::ST_ABORT_BIT]) begin
            prot_abort_ff <= 1'b0;
          end
        end
        sector_overlay_pkg::OFS_PROT_CFG: begin
          if (!otp_wd[sector_overlay_pkg::PERSIST_BIT]
              && !otp_wd[sector_overlay_pkg::PASSWORD_BIT]) begin
            prot_abort_ff <= 1'b1;
          end else begin
            prot_cfg_ff <= prot_cfg_ff & otp_wd;
          end
        end
        default: prot_cfg_ff <= prot_cfg_ff;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dv/sector_overlay_cmd_assertions.sv
/* Checker of decoder port timing.
   Assumes binding onto sector_overlay_cmd. */
`default_nettype none
module sector_overlay_cmd_assertions (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire sector_overlay_pkg::cmd_t     cmd,
  input wire sector_overlay_pkg::resp_t    resp,
  input wire sector_overlay_pkg::op_stat_t op_stat,
  input wire sector_overlay_pkg::op_req_t  op_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence w(a, c);
    cmd.valid && cmd.wr && cmd.addr[10:0] == a && cmd.data[7:0] == c;
  endsequence
  sequence lock_set;
    w(11'h555, 8'hAA) ##1 w(11'h2AA, 8'h55) ##1 w(11'h555, 8'hE0) ##1
    w(cmd.addr[10:0], 8'hA0) ##1 cmd.valid && cmd.wr && cmd.data == 16'h0000;
  endsequence
  AST_LOCK_SET: assert property (lock_set ##1 cmd.valid && !cmd.wr
    && cmd.addr[24:11] == $past(cmd.addr[24:11])
    |=> resp.data == 16'hFFFE) else $error("lock not read back");
  AST_READ_ANSWER: assert property (cmd.valid && !cmd.wr
    |=> resp.valid) else $error("read unanswered");
  AST_NO_STRAY: assert property (resp.valid
    |-> $past(cmd.valid && !cmd.wr)) else $error("stray answer");
  AST_ERASE_SUS: assert property (op_req.erase_sus |-> $past(
    op_stat.erase_busy && cmd.valid && cmd.data[7:0] == 8'hB0))
    else $error("bad erase suspend");
  AST_PROG_SUS: assert property (op_req.prog_sus
    |-> $past(op_stat.prog_busy)) else $error("bad program suspend");
  AST_ERASE_RES: assert property (op_req.erase_res
    |-> $past(op_stat.erase_suspended)) else $error("bad erase resume");
  AST_PROG_RES: assert property (op_req.prog_res
    |-> $past(op_stat.prog_suspended)) else $error("bad program resume");
  AST_PROG_ADDR: assert property (op_req.prog
    |-> op_req.addr == $past(cmd.addr)) else $error("program address");
endmodule
bind sector_overlay_cmd sector_overlay_cmd_assertions u_chk (
  .aclk, .aresetn, .cmd, .resp, .op_stat, .op_req);
`default_nettype wire

// ===== dv/cmd_host.sv
/* Host model issuing command bus cycles.
   Assumes the decoder samples cmd on rising aclk. */
`default_nettype none
module cmd_host (
  input  wire logic                      aclk,
  output var  sector_overlay_pkg::cmd_t  cmd,
  input  wire sector_overlay_pkg::resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd = '0;
  task automatic wr(input logic [24:0] a, input logic [15:0] d);
    @(posedge aclk) cmd <= '{1'b1, 1'b1, 1'b1, a, d};
  endtask
  task automatic idle();
    @(posedge aclk) cmd.valid <= 1'b0;
    #1;
  endtask
  // Only the first word is used; data flips so no stale value lingers
  task automatic rd(input logic [24:0] a, output logic [15:0] d);
    @(posedge aclk) cmd <= '{1'b1, 1'b0, 1'b1, a, ~cmd.data};
    idle();
    d = resp.valid ? resp.data : 'x;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
/* Self-checking bench of the overlay command decoder.
   Assumes the package, host model and checker are compiled first. */
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         aclk, aresetn;
  sector_overlay_pkg::axi_req_t axi_req;
  sector_overlay_pkg::axi_rsp_t axi_rsp;
  sector_overlay_pkg::cmd_t     cmd;
  sector_overlay_pkg::resp_t    resp;
  sector_overlay_pkg::ecc_evt_t ecc_evt;
  sector_overlay_pkg::op_stat_t op_stat;
  sector_overlay_pkg::op_req_t  op_req;
  logic [263:0]                 pu;
  logic [15:0]                  d;
  logic [31:0]                  v;
  logic [24:0]                  ea;
  logic [1:0]                   rr;
  int                           error_cnt, n_tests;
  wire  [15:0]                  arr = cmd.addr[15:0] ^ 16'h5A3C;
  cmd_host host (.aclk, .cmd, .resp);
  sector_overlay_cmd dut (.aclk, .aresetn, .axi_req, .axi_rsp, .cmd, .resp,
    .arr_rdata(arr), .ecc_word(~arr), .id_rdata(16'h1234),
    .persist_unlock(pu), .ecc_evt, .op_stat, .op_req);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic axr(input logic [7:0] a);
    @(posedge aclk) axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    v = axi_rsp.rdata;
    rr = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
  task automatic unlock(input logic [7:0] c);
    host.wr({14'($urandom), 11'h555}, {8'($urandom), 8'hAA});
    host.wr({14'($urandom), 11'h2AA}, {8'($urandom), 8'h55});
    host.wr({14'($urandom), 11'h555}, {8'($urandom), c});
  endtask
  task automatic cw(input logic [7:0] c);
    host.wr(ea, {8'($urandom), c});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {axi_req, ecc_evt, op_stat, aresetn} = '0;
    pu = '1;
    void'($urandom(90));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_req.awaddr <= 8'h08;
    axi_req.wdata <= 32'h0000_FFF9;
    {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'b111;
    axi_req.wstrb <= 4'hF;
    do begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    axr(8'h08);
    `CHK("prot_cfg", 32'h0000_FFFF, v)
    axr(8'h40);
    `CHK("unmapped", 2'h2, rr)
    axr(8'h04);
    `CHK("status", 34'h0_0000_0010, {rr, v})
    $display("register test done");
    repeat (6) begin
      ea = 25'($urandom);
      host.rd(ea, d);
      `CHK("array", ea[15:0] ^ 16'h5A3C, d)
    end
    unlock(8'hE0);
    cw(8'hA0);
    host.wr(ea, 16'h0000);
    host.rd(ea ^ 25'h0FF, d);
    `CHK("lock_set", 16'hFFFE, d)
    cw(8'h60);
    host.rd(ea, d);
    `CHK("prot_status", 16'hFFFC, d)
    cw(8'hA0);
    host.wr(ea, 16'h0001);
    host.rd(ea, d);
    `CHK("lock_clear", 16'hFFFF, d)
    cw(8'h90);
    cw(8'h00);
    host.rd(ea, d);
    `CHK("exit", ea[15:0] ^ 16'h5A3C, d)
    $display("lock test done");
    @(posedge aclk) ecc_evt <= '{1'b1, ea};
    @(posedge aclk) ecc_evt.valid <= 1'b0;
    unlock(8'h75);
    host.rd(ea, d);
    `CHK("ecc_word", ~(ea[15:0] ^ 16'h5A3C), d)
    cw(8'h60);
    host.rd(25'h1, d);
    `CHK("err_lo", ea[15:0], d)
    cw(8'h50);
    cw(8'h60);
    host.rd(25'h3, d);
    `CHK("err_cnt", 16'h0000, d)
    cw(8'hF0);
    cw(8'hB0);
    host.idle();
    `CHK("sus_refused", 1'b0, op_req.erase_sus)
    op_stat.erase_busy <= 1'b1;
    cw(8'hB0);
    host.idle();
    `CHK("sus_taken", 1'b1, op_req.erase_sus)
    $display("ecc and suspend test done");
    unlock(8'hA0);
    d = 16'($urandom);
    host.wr(ea, d);
    host.idle();
    `CHK("prog", 1'b1, op_req.prog)
    `CHK("prog_data", {ea, d}, {op_req.addr, op_req.data})
    unlock(8'hA0);
    host.idle();
    @(posedge aclk) op_stat.wbuf_abort <= 1'b1;
    @(posedge aclk) op_stat.wbuf_abort <= 1'b0;
    cw(8'hF0);
    host.idle();
    axr(8'h04);
    `CHK("abort", 1'b1, v[3])
    unlock(8'hF0);
    host.idle();
    axr(8'h04);
    `CHK("abort_exit", 1'b0, v[3])
    unlock(8'h90);
    host.rd(ea, d);
    `CHK("id", 16'h1234, d)
    cw(8'hF0);
    host.rd(ea, d);
    `CHK("id_exit", ea[15:0] ^ 16'h5A3C, d)
    op_stat.erase_suspended <= 1'b1;
    cw(8'h30);
    host.idle();
    `CHK("res_taken", 1'b1, op_req.erase_res)
    $display("program, abort and id test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
